// *** logic/gms_pkg.sv ***
// gms_pkg: offsets, field positions, reset values and carriers shared by
// the gigabit control/status register block.
// assumes a 16-bit register word placed in the low bits of a wishbone word.
package gms_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] GMS_IDX_CTRL = 8'h09;
  localparam logic [7:0] GMS_IDX_STAT = 8'h0A;
  localparam logic [7:0] GMS_IDX_RSV_LO = 8'h0B;
  localparam logic [7:0] GMS_IDX_RSV_HI = 8'h0E;
  localparam logic [7:0] GMS_IDX_IRQ_STAT = 8'h18;
  localparam logic [7:0] GMS_IDX_IRQ_MASK = 8'h19;

  // control field positions
  localparam int GMS_CTRL_TEST_HI = 15;
  localparam int GMS_CTRL_TEST_LO = 13;
  localparam int GMS_CTRL_MAN_EN = 12;
  localparam int GMS_CTRL_MAN_ADV = 11;
  localparam int GMS_CTRL_PORT_TYPE = 10;
  localparam int GMS_CTRL_ADV_FD = 9;
  localparam int GMS_CTRL_ADV_HD = 8;

  // status field positions
  localparam int GMS_STAT_FAULT = 15;
  localparam int GMS_STAT_ROLE = 14;
  localparam int GMS_STAT_LOC_RX = 13;
  localparam int GMS_STAT_REM_RX = 12;
  localparam int GMS_STAT_LP_FD = 11;
  localparam int GMS_STAT_LP_HD = 10;
  localparam int GMS_STAT_LP_ASYM = 9;
  localparam int GMS_STAT_RSV = 8;

  // interrupt event bit positions
  localparam int GMS_EV_FAULT = 0;
  localparam int GMS_EV_LOC_RX = 1;
  localparam int GMS_EV_REM_RX = 2;
  localparam int GMS_EV_ROLE = 3;
  localparam int GMS_EV_N = 4;

  // reset values
  localparam logic [2:0] GMS_TEST_RST = 3'h0;
  localparam logic [15:0] GMS_STAT_RST = 16'h0000;
  localparam logic [GMS_EV_N-1:0] GMS_IRQ_RST = 4'h0;
  localparam logic [7:0] GMS_IDLE_RST = 8'h00;
  localparam logic [31:0] GMS_UNMAPPED_DATA = 32'h0000_0000;
  localparam logic GMS_STRAP_BIT_RST = 1'h0;
  localparam logic GMS_ADV_DUPLEX_RST = 1'h1;
  localparam logic [7:0] GMS_IDLE_MAX = 8'hFF;
  // cycles after reset release: straps are caught, then edges are armed
  localparam logic [1:0] GMS_STRAP_LOAD_CNT = 2'h2;
  localparam logic [1:0] GMS_SETTLED_CNT = 2'h3;

  typedef enum logic [2:0] {
    GMS_TEST_NORMAL,
    GMS_TEST_MODE1,
    GMS_TEST_MODE2,
    GMS_TEST_MODE3,
    GMS_TEST_MODE4
  } gms_test_e;

  // strap levels caught at reset
  typedef struct packed {
    logic man_en;
    logic man_adv;
    logic port_type;
    logic adv_fd;
    logic adv_hd;
  } gms_strap_s;

  // state reported by the link-side logic
  typedef struct packed {
    logic fault;
    logic role_resolution_result;
    logic loc_rx_ok;
    logic rem_rx_ok;
    logic partner_gig_full_capable;
    logic partner_gig_half_capable;
    logic partner_asym_pause_capable;
    logic idle_err_inc;
  } gms_link_s;

  // control outputs toward the link-side logic
  typedef struct packed {
    logic [2:0] test_sel;
    logic man_en;
    logic man_adv;
    logic port_type;
    logic adv_fd;
    logic adv_hd;
  } gms_ctrl_s;

endpackage

// *** logic/gms_regs.sv ***
// gms_regs: gigabit master/slave control and status registers on a
// classic wishbone slave, with strap defaults and a masked interrupt.
// assumes strap and link-state inputs are asynchronous pins; the
// idle error increment is a level toggled per error by the link side.
// straps must stay steady from reset until they are caught.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module gms_regs
  import gms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire gms_strap_s strap_i,
  input wire gms_link_s link_i,
  output gms_ctrl_s ctrl_o,
  output logic adv_master_o,
  output logic man_cfg_active_o,
  output logic irq_o
);

  localparam int SYNC_W = $bits(gms_strap_s) + $bits(gms_link_s);

  logic [SYNC_W-1:0] sync_q;
  gms_strap_s strap_s;
  gms_link_s link_s;

  gms_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({strap_i, link_i}),
    .q_o(sync_q)
  );

  assign {strap_s, link_s} = sync_q;

  // control state
  logic [2:0] test_reg;
  logic man_en_reg;
  logic man_adv_reg;
  logic port_type_reg;
  logic adv_fd_reg;
  logic adv_hd_reg;
  logic [1:0] strap_cnt_reg;
  logic [7:0] idle_cnt_reg;
  logic idle_tog_reg;
  gms_link_s link_prev_reg;
  logic [GMS_EV_N-1:0] irq_stat_reg;
  logic [GMS_EV_N-1:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  gms_ctrl_s ctrl_reg;
  logic adv_master_reg;
  logic man_cfg_active_reg;
  logic irq_reg;

  function automatic logic is_idx(input logic [9:0] a,
                                  input logic [7:0] idx);
    is_idx = (a[9:2] == idx);
  endfunction

  // bus decode
  wire req = cyc_i && stb_i && !ack_reg;
  wire wr = req && we_i;
  wire lo_lane = sel_i[0];
  wire hi_lane = sel_i[1];
  wire hit_ctrl = is_idx(adr_i, GMS_IDX_CTRL);
  wire hit_stat = is_idx(adr_i, GMS_IDX_STAT);
  wire hit_istat = is_idx(adr_i, GMS_IDX_IRQ_STAT);
  wire hit_imask = is_idx(adr_i, GMS_IDX_IRQ_MASK);
  wire wr_ctrl = wr && hit_ctrl && hi_lane;
  wire wr_istat = wr && hit_istat && lo_lane;
  wire wr_imask = wr && hit_imask && lo_lane;

  // straps settle through the synchroniser before they are caught
  wire strap_load = (strap_cnt_reg == GMS_STRAP_LOAD_CNT);
  // the synchroniser leaves reset at zero, so the first real pin levels
  // look like edges; events and idle counts wait one more cycle for that
  wire settled = (strap_cnt_reg == GMS_SETTLED_CNT);

  wire [15:0] ctrl_word = {test_reg, man_en_reg, man_adv_reg, port_type_reg,
                           adv_fd_reg, adv_hd_reg, 8'h00};

  wire [15:0] stat_word = {link_s.fault,
                           link_s.role_resolution_result,
                           link_s.loc_rx_ok,
                           link_s.rem_rx_ok,
                           link_s.partner_gig_full_capable,
                           link_s.partner_gig_half_capable,
                           link_s.partner_asym_pause_capable,
                           1'b0,
                           idle_cnt_reg};

  // reserved indices 0x0B-0x0E fall through to zero
  wire [31:0] rd_data =
    hit_ctrl ? {16'h0000, ctrl_word} :
    hit_stat ? {16'h0000, stat_word} :
    hit_istat ? {28'h0000000, irq_stat_reg} :
    hit_imask ? {28'h0000000, irq_mask_reg} :
    GMS_UNMAPPED_DATA;

  // only codes 000-100 are legal; other codes keep the old mode
  wire [2:0] test_wdata = dat_i[GMS_CTRL_TEST_HI:GMS_CTRL_TEST_LO];
  wire test_ok = (test_wdata <= 3'(GMS_TEST_MODE4));

  // events
  wire [GMS_EV_N-1:0] ev_now;
  wire [GMS_EV_N-1:0] ev_was;
  wire [GMS_EV_N-1:0] ev_raw;
  wire [GMS_EV_N-1:0] ev;
  assign ev_now[GMS_EV_FAULT] = link_s.fault;
  assign ev_now[GMS_EV_LOC_RX] = link_s.loc_rx_ok;
  assign ev_now[GMS_EV_REM_RX] = link_s.rem_rx_ok;
  assign ev_now[GMS_EV_ROLE] = link_s.role_resolution_result;
  assign ev_was[GMS_EV_FAULT] = link_prev_reg.fault;
  assign ev_was[GMS_EV_LOC_RX] = link_prev_reg.loc_rx_ok;
  assign ev_was[GMS_EV_REM_RX] = link_prev_reg.rem_rx_ok;
  assign ev_was[GMS_EV_ROLE] = link_prev_reg.role_resolution_result;
  // fault counts only as it appears; the other levels count either way
  for (genvar g = 0; g < GMS_EV_N; g = g + 1) begin : g_ev
    if (g == GMS_EV_FAULT) begin : g_rise
      assign ev_raw[g] = ev_now[g] && !ev_was[g];
    end else begin : g_change
      assign ev_raw[g] = ev_now[g] ^ ev_was[g];
    end
  end
  assign ev = settled ? ev_raw : '0;

  // set wins over a write-one clear in the same cycle
  wire [GMS_EV_N-1:0] irq_clr = wr_istat ? dat_i[GMS_EV_N-1:0] : '0;
  wire [GMS_EV_N-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | ev;

  wire idle_inc = settled && (link_s.idle_err_inc ^ idle_tog_reg);
  // saturate rather than wrap, so a large count never reads small
  wire [7:0] idle_next = (idle_inc && idle_cnt_reg != GMS_IDLE_MAX) ?
                         8'(idle_cnt_reg + 8'h01) : idle_cnt_reg;

  wire adv_master_next = man_en_reg && man_adv_reg;

  // a strap load beats a bus write that lands in the same cycle
  wire ctrl_wr = wr_ctrl && !strap_load;
  wire [1:0] strap_cnt_next = (strap_cnt_reg == GMS_SETTLED_CNT) ?
                              strap_cnt_reg : 2'(strap_cnt_reg + 2'h1);
  wire [2:0] test_next = (ctrl_wr && test_ok) ? test_wdata :
                         test_reg;
  wire man_en_next = strap_load ? strap_s.man_en :
                     ctrl_wr ? dat_i[GMS_CTRL_MAN_EN] :
                     man_en_reg;
  wire man_adv_next = strap_load ? strap_s.man_adv :
                      ctrl_wr ? dat_i[GMS_CTRL_MAN_ADV] :
                      man_adv_reg;
  // no bus path: software can read the port type but never change it
  wire port_type_next = strap_load ? strap_s.port_type :
                        port_type_reg;
  wire adv_fd_next = strap_load ? strap_s.adv_fd :
                     ctrl_wr ? dat_i[GMS_CTRL_ADV_FD] :
                     adv_fd_reg;
  wire adv_hd_next = strap_load ? strap_s.adv_hd :
                     ctrl_wr ? dat_i[GMS_CTRL_ADV_HD] :
                     adv_hd_reg;
  wire [GMS_EV_N-1:0] irq_mask_next = wr_imask ? dat_i[GMS_EV_N-1:0] :
                                      irq_mask_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_cnt_reg <= 2'h0;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_reg <= GMS_TEST_RST;
    end else begin
      test_reg <= test_next;
    end
  end

  // man_en, man_adv and port_type sit low until the straps are caught
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      man_en_reg <= GMS_STRAP_BIT_RST;
      man_adv_reg <= GMS_STRAP_BIT_RST;
      port_type_reg <= GMS_STRAP_BIT_RST;
    end else begin
      man_en_reg <= man_en_next;
      man_adv_reg <= man_adv_next;
      port_type_reg <= port_type_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_fd_reg <= GMS_ADV_DUPLEX_RST;
      adv_hd_reg <= GMS_ADV_DUPLEX_RST;
    end else begin
      adv_fd_reg <= adv_fd_next;
      adv_hd_reg <= adv_hd_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_reg <= GMS_IDLE_RST;
      idle_tog_reg <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_next;
      idle_tog_reg <= link_s.idle_err_inc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_prev_reg <= '0;
    end else begin
      link_prev_reg <= link_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= GMS_IRQ_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= GMS_IRQ_RST;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // read data holds until the next read is taken, so a slow master still
  // finds it
  wire [31:0] dat_next = (req && !we_i) ? rd_data : dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= GMS_UNMAPPED_DATA;
    end else begin
      dat_reg <= dat_next;
    end
  end

  // ctrl_o, adv_master_o and man_cfg_active_o are registered copies, one cycle behind the registers
  gms_ctrl_s ctrl_next;
  assign ctrl_next = '{test_sel: test_reg, man_en: man_en_reg,
                       man_adv: man_adv_reg, port_type: port_type_reg,
                       adv_fd: adv_fd_reg, adv_hd: adv_hd_reg};
  // irq looks at the next status so it rises with the status bit
  wire irq_next = |(irq_stat_next & irq_mask_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_master_reg <= 1'b0;
      man_cfg_active_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      adv_master_reg <= adv_master_next;
      man_cfg_active_reg <= man_en_reg;
      irq_reg <= irq_next;
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign ctrl_o = ctrl_reg;
  assign adv_master_o = adv_master_reg;
  assign man_cfg_active_o = man_cfg_active_reg;
  assign irq_o = irq_reg;

endmodule

// *** logic/gms_sync.sv ***
// gms_sync: two flip-flop synchroniser for a bus of levels.
// assumes inputs come from pins outside the clk_i domain.
`timescale 1ns/1ps
module gms_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

// *** sim/gms_regs_assertions.sv ***
// gms_regs_assertions: bus and control relations of gms_regs.
// assumes it is bound to gms_regs and sees only that module's ports.
`timescale 1ns/1ps
module gms_regs_assertions
  import gms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire gms_strap_s strap_i,
  input wire gms_link_s link_i,
  input wire gms_ctrl_s ctrl_o,
  input wire logic adv_master_o,
  input wire logic man_cfg_active_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // remembers the taken read so read data can be tied to its index
  logic last_rd;
  logic [7:0] last_idx;
  always_ff @(posedge clk_i) begin
    last_rd <= cyc_i & stb_i & ~we_i & ~ack_o;
    last_idx <= adr_i[9:2];
  end
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd(logic [7:0] idx);
    ack_o && last_rd && last_idx == idx;
  endsequence
  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  property p_ctrl_rd;
    s_rd(GMS_IDX_CTRL) |-> dat_o == {16'h0000, ctrl_o, 8'h00};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read differs from control outputs");
  property p_test_legal;
    ctrl_o.test_sel <= 3'h4;
  endproperty
  a_test_legal: assert property (p_test_legal)
    else $error("illegal test code reached the output");
  property p_adv;
    adv_master_o == (ctrl_o.man_en & ctrl_o.man_adv);
  endproperty
  a_adv: assert property (p_adv)
    else $error("forced master output wrong");
  property p_man;
    man_cfg_active_o == ctrl_o.man_en;
  endproperty
  a_man: assert property (p_man)
    else $error("manual enable output wrong");
  property p_stat_rsv;
    s_rd(GMS_IDX_STAT) |-> !dat_o[GMS_STAT_RSV] && dat_o[31:16] == 16'h0;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv)
    else $error("reserved status bit not zero");
  property p_rsv_zero;
    ack_o && last_rd && last_idx >= GMS_IDX_RSV_LO &&
      last_idx <= GMS_IDX_RSV_HI |-> dat_o == GMS_UNMAPPED_DATA;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved index read not zero");
endmodule

// *** sim/tb.sv ***
// tb: self-checking bench for gms_regs driven over classic wishbone.
// assumes gms_pkg, the design files and the checker are compiled first.
`timescale 1ns/1ps
module tb;
  import gms_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [3:0] sel_i = 4'h0;
  logic [9:0] adr_i = 10'h000;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, adv_master_o, man_cfg_active_o, irq_o;
  gms_strap_s strap_i = '0;
  gms_link_s link_i = '0;
  gms_ctrl_s ctrl_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  logic [39:0] exp_q[$];
  logic [39:0] e;
  logic [15:0] cur;
  logic [4:0] pick;
  gms_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .strap_i(strap_i), .link_i(link_i), .ctrl_o(ctrl_o),
    .adv_master_o(adv_master_o), .man_cfg_active_o(man_cfg_active_o),
    .irq_o(irq_o));
  always #25 clk_i = ~clk_i;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish(bit hung);
    if (hung) n_errors++;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(logic [7:0] idx, logic w, logic [31:0] d, logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic rd(logic [7:0] idx, logic [31:0] exp);
    exp_q.push_back({idx, exp});
    wb(idx, 0, 32'h0, 4'hF);
  endtask
  // a hang still reaches the verdict; the whole run needs ~190 cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n > 4000) tally_and_finish(1);
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk($sformatf("reg %h", e[39:32]), dat_o, e[31:0]);
    end
  end
  initial begin
    void'($urandom(63));
    strap_i <= gms_strap_s'(5'($urandom));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    repeat (6) @(posedge clk_i);
    cur = {3'h0, strap_i, 8'h00};
    rd(GMS_IDX_CTRL, {16'h0, cur});
    rd(GMS_IDX_STAT, 32'h0);
    for (int c = 0; c < 8; c++) begin
      pick = 5'($urandom);
      wb(GMS_IDX_CTRL, 1, {16'h0, 3'(c), pick, 8'hFF}, 4'h3);
      if (c < 5) cur[15:13] = 3'(c);
      cur[12:11] = pick[4:3];
      cur[9:8] = pick[1:0];
      rd(GMS_IDX_CTRL, {16'h0, cur});
      chk("adv_master", adv_master_o, cur[12] & cur[11]);
    end
    // lane 1 missing, so the control write must be dropped
    wb(GMS_IDX_CTRL, 1, 32'h0000_FFFF, 4'h1);
    rd(GMS_IDX_CTRL, {16'h0, cur});
    link_i <= gms_link_s'(8'($urandom) & 8'hFE);
    repeat (4) @(posedge clk_i);
    wb(GMS_IDX_STAT, 1, 32'h0000_FFFF, 4'hF);
    rd(GMS_IDX_STAT, {16'h0, link_i[7:1], 1'b0, 8'h00});
    repeat (5) begin
      link_i.idle_err_inc <= ~link_i.idle_err_inc;
      repeat (3) @(posedge clk_i);
    end
    rd(GMS_IDX_STAT, {16'h0, link_i[7:1], 1'b0, 8'h05});
    for (int i = GMS_IDX_RSV_LO; i <= GMS_IDX_RSV_HI; i++) begin
      wb(8'(i), 1, 32'h0000_FFFF, 4'hF);
      rd(8'(i), 32'h0);
    end
    rd(8'h30, GMS_UNMAPPED_DATA);
    link_i <= '0;
    repeat (5) @(posedge clk_i);
    wb(GMS_IDX_IRQ_STAT, 1, 32'hF, 4'h1);
    rd(GMS_IDX_IRQ_STAT, 32'h0);
    wb(GMS_IDX_IRQ_MASK, 1, 32'h1, 4'h1);
    link_i.fault <= 1;
    repeat (5) @(posedge clk_i);
    chk("irq", irq_o, 32'h1);
    rd(GMS_IDX_IRQ_STAT, 32'h1);
    wb(GMS_IDX_IRQ_STAT, 1, 32'h1, 4'h1);
    repeat (2) @(posedge clk_i);
    chk("irq", irq_o, 32'h0);
    wb(GMS_IDX_IRQ_MASK, 1, 32'h0, 4'h1);
    link_i.fault <= 0;
    repeat (5) @(posedge clk_i);
    link_i.fault <= 1;
    repeat (5) @(posedge clk_i);
    chk("irq", irq_o, 32'h0);
    rd(GMS_IDX_IRQ_STAT, 32'h1);
    rd(GMS_IDX_IRQ_MASK, 32'h0);
    @(posedge clk_i);
    tally_and_finish(0);
  end
endmodule
bind gms_regs gms_regs_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .strap_i(strap_i),
  .link_i(link_i), .ctrl_o(ctrl_o), .adv_master_o(adv_master_o),
  .man_cfg_active_o(man_cfg_active_o), .irq_o(irq_o));
